// file: core/spcm_map.vh
// Constants of the serial command interface: opcodes, arguments, buffer limits.
`ifndef SPCM_MAP_VH
`define SPCM_MAP_VH

// ****************************************************************
// Opcodes in the upper three bits of the first byte.
// ****************************************************************
`define SPCM_OP_REG_READ   3'h0
`define SPCM_OP_BUF_READ   3'h1
`define SPCM_OP_REG_WRITE  3'h2
`define SPCM_OP_BUF_WRITE  3'h3
`define SPCM_OP_BIT_SET    3'h4
`define SPCM_OP_BIT_CLEAR  3'h5
`define SPCM_OP_SOFT_RESET 3'h7

// ****************************************************************
// Field positions inside the first byte.
// ****************************************************************
`define SPCM_OP_MSB        7
`define SPCM_OP_LSB        5
`define SPCM_ARG_MSB       4
`define SPCM_ARG_LSB       0

// ****************************************************************
// Fixed arguments and fill values.
// ****************************************************************
`define SPCM_ARG_BUF       5'h1A
`define SPCM_ARG_RESET     5'h1F
`define SPCM_DUMMY_BYTE    8'h00
`define SPCM_LAST_BIT      3'h7

// ****************************************************************
// Packet buffer geometry, pointer reset values and write FIFO size.
// ****************************************************************
`define SPCM_BUF_DEPTH     8192
`define SPCM_BUF_ADDR_W    13
`define SPCM_BUF_TOP       13'h1FFF
`define SPCM_BUF_BOTTOM    13'h0000
`define SPCM_PTR_RESET     13'h0000
`define SPCM_FIFO_DEPTH    16
`define SPCM_FIFO_AW       4

`endif

// file: core/spcm_sync.v
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none

module spcm_sync #(
  parameter         W   = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input  wire         clk,
  input  wire         reset,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  // The first stage is read only by the second stage.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= RST;
      q      <= RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // spcm_sync

`default_nettype wire

// file: core/spcm_fifo.v
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none

module spcm_fifo #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clk,
  input  wire         reset,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  // Full and empty come straight from the fill count.
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers wrap at the depth; the count tracks both sides.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Storage holds no reset; only written slots are ever read.
  always @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule // spcm_fifo

`default_nettype wire

// file: core/spcm_spi_cmd.v
// Serial command front end: decodes host instructions, serves registers and packet buffer.
`timescale 1ns/1ns
`default_nettype none
`include "spcm_map.vh"

module spcm_spi_cmd #(
  parameter ADDR_W     = `SPCM_BUF_ADDR_W,
  parameter DEPTH      = `SPCM_BUF_DEPTH,
  parameter FIFO_DEPTH = `SPCM_FIFO_DEPTH,
  parameter FIFO_AW    = `SPCM_FIFO_AW
) (
  input  wire              clk,
  input  wire              reset,
  input  wire              cs_n_pin,
  input  wire              sck_pin,
  input  wire              si_pin,
  output reg               so_q,
  output reg               so_oe_q,
  input  wire              auto_increment_en,
  input  wire [ADDR_W-1:0] rx_region_start,
  input  wire [ADDR_W-1:0] rx_region_end,
  input  wire              rd_ptr_load,
  input  wire              wr_ptr_load,
  input  wire [ADDR_W-1:0] ptr_load_value,
  input  wire              mem_hold,
  input  wire              reg_is_eth,
  input  wire [7:0]        reg_rdata,
  output reg  [4:0]        reg_addr_q,
  output reg  [7:0]        reg_wdata_q,
  output reg               reg_wr_q,
  output reg               soft_reset_q,
  output reg  [ADDR_W-1:0] buf_read_ptr_q,
  output reg  [ADDR_W-1:0] buf_write_ptr_q,
  output reg               wbuf_full_q
);

  // ****************************************************************
  // Decoder states.
  // ****************************************************************
  localparam [2:0] ST_OP    = 3'h0;
  localparam [2:0] ST_RREG  = 3'h1;
  localparam [2:0] ST_RBUF  = 3'h2;
  localparam [2:0] ST_WREG  = 3'h3;
  localparam [2:0] ST_WBUF  = 3'h4;
  localparam [2:0] ST_BSET  = 3'h5;
  localparam [2:0] ST_BCLR  = 3'h6;
  localparam [2:0] ST_IGN   = 3'h7;

  localparam [ADDR_W-1:0] PTR_TOP    = `SPCM_BUF_TOP;
  localparam [ADDR_W-1:0] PTR_BOTTOM = `SPCM_BUF_BOTTOM;
  localparam [ADDR_W-1:0] PTR_ONE    = {{(ADDR_W-1){1'b0}}, 1'b1};

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  wire [2:0]        pins_s;
  wire              cs_act;
  wire              sck_s;
  wire              si_s;
  reg               sck_d_q;
  wire              sck_rise;
  wire              sck_fall;
  reg  [2:0]        state_q;
  reg  [2:0]        bit_q;
  reg  [6:0]        rx_q;
  reg  [7:0]        tx_q;
  reg               dummy_q;
  wire [7:0]        rx_full;
  wire              byte_done;
  reg  [7:0]        src_byte;
  reg               src_is_dummy;
  reg               push_q;
  reg  [7:0]        push_data_q;
  wire              push_ready;
  wire              fifo_valid;
  wire [7:0]        fifo_data;
  wire              drain;
  reg  [7:0]        buf_mem_q [0:DEPTH-1];
  wire [7:0]        mem_rdata;
  reg  [ADDR_W-1:0] rd_next;
  reg  [ADDR_W-1:0] wr_next;

  // ****************************************************************
  // Pin synchronisation and clock edge detection.
  // ****************************************************************

  // Select resets inactive so no frame is seen before the pins settle.
  spcm_sync #(
    .W   (3),
    .RST (3'h4)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({cs_n_pin, sck_pin, si_pin}),
    .q     (pins_s)
  );

  assign cs_act = ~pins_s[2];
  assign sck_s  = pins_s[1];
  assign si_s   = pins_s[0];

  // Previous clock level for edge finding.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_d_q <= 1'b0;
    end else begin
      sck_d_q <= sck_s;
    end
  end

  assign sck_rise = cs_act & sck_s & ~sck_d_q;
  assign sck_fall = cs_act & ~sck_s & sck_d_q;

  // A byte completes on the rise of its eighth bit.
  assign rx_full   = {rx_q, si_s};
  assign byte_done = sck_rise & (bit_q == `SPCM_LAST_BIT);

  // ****************************************************************
  // Pointer arithmetic.
  // ****************************************************************

  // Next read address: receive wrap first, then top-of-memory wrap.
  always @* begin
    rd_next = buf_read_ptr_q + PTR_ONE;
    if (buf_read_ptr_q == rx_region_end) begin
      rd_next = rx_region_start;
    end else if (buf_read_ptr_q == PTR_TOP) begin
      rd_next = PTR_BOTTOM;
    end
  end

  // Next write address ignores the receive region entirely.
  always @* begin
    wr_next = buf_write_ptr_q + PTR_ONE;
    if (buf_write_ptr_q == PTR_TOP) begin
      wr_next = PTR_BOTTOM;
    end
  end

  // ****************************************************************
  // Instruction decoder and input shifter.
  // ****************************************************************

  // Bits shift in on every rise; a full byte steers the state machine.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q      <= ST_OP;
      bit_q        <= 3'h0;
      rx_q         <= 7'h00;
      reg_addr_q   <= 5'h00;
      reg_wdata_q  <= 8'h00;
      reg_wr_q     <= 1'b0;
      soft_reset_q <= 1'b0;
      push_q       <= 1'b0;
      push_data_q  <= 8'h00;
    end else begin
      reg_wr_q     <= 1'b0;
      soft_reset_q <= 1'b0;
      push_q       <= 1'b0;
      if (!cs_act) begin
        state_q <= ST_OP;
        bit_q   <= 3'h0;
        rx_q    <= 7'h00;
      end else if (sck_rise) begin
        bit_q <= bit_q + 3'h1;
        rx_q  <= rx_full[6:0];
      end
      if (byte_done) begin
        case (state_q)
          ST_OP: begin
            reg_addr_q <= rx_full[`SPCM_ARG_MSB:`SPCM_ARG_LSB];
            case (rx_full[`SPCM_OP_MSB:`SPCM_OP_LSB])
              `SPCM_OP_REG_READ: begin
                state_q <= ST_RREG;
              end
              `SPCM_OP_BUF_READ: begin
                if (rx_full[4:0] == `SPCM_ARG_BUF) begin
                  state_q <= ST_RBUF;
                end else begin
                  state_q <= ST_IGN;
                end
              end
              `SPCM_OP_REG_WRITE: begin
                state_q <= ST_WREG;
              end
              `SPCM_OP_BUF_WRITE: begin
                if (rx_full[4:0] == `SPCM_ARG_BUF) begin
                  state_q <= ST_WBUF;
                end else begin
                  state_q <= ST_IGN;
                end
              end
              `SPCM_OP_BIT_SET: begin
                state_q <= ST_BSET;
              end
              `SPCM_OP_BIT_CLEAR: begin
                state_q <= ST_BCLR;
              end
              `SPCM_OP_SOFT_RESET: begin
                soft_reset_q <= (rx_full[4:0] == `SPCM_ARG_RESET);
                state_q      <= ST_IGN;
              end
              default: begin
                state_q <= ST_IGN;
              end
            endcase
          end
          ST_WREG: begin
            reg_wr_q    <= 1'b1;
            reg_wdata_q <= rx_full;
          end
          ST_BSET: begin
            reg_wr_q    <= reg_is_eth;
            reg_wdata_q <= reg_rdata | rx_full;
          end
          ST_BCLR: begin
            reg_wr_q    <= reg_is_eth;
            reg_wdata_q <= reg_rdata & ~rx_full;
          end
          ST_WBUF: begin
            push_q      <= 1'b1;
            push_data_q <= rx_full;
          end
          default: begin
            state_q <= state_q;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Output byte source.
  // ****************************************************************

  // At each byte boundary pick what the next output byte carries.
  always @* begin
    src_byte     = 8'h00;
    src_is_dummy = 1'b0;
    case (state_q)
      ST_RREG: begin
        // dummy before MAC or MII data
        if (!reg_is_eth && dummy_q) begin
          src_byte     = `SPCM_DUMMY_BYTE;
          src_is_dummy = 1'b1;
        end else begin
          src_byte = reg_rdata;
        end
      end
      ST_RBUF: begin
        src_byte = mem_rdata;
      end
      default: begin
        src_byte = 8'h00;
      end
    endcase
  end

  // ****************************************************************
  // Serial output shifter.
  // ****************************************************************

  // Output moves on the fall; a new byte is loaded when no bits are pending.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
      tx_q    <= 8'h00;
      dummy_q <= 1'b1;
    end else begin
      so_oe_q <= cs_act;
      if (!cs_act) begin
        so_q    <= 1'b0;
        tx_q    <= 8'h00;
        dummy_q <= 1'b1;
      end else if (sck_fall) begin
        if (bit_q == 3'h0) begin
          so_q <= src_byte[7];
          tx_q <= {src_byte[6:0], 1'b0};
          if (src_is_dummy) begin
            dummy_q <= 1'b0;
          end
        end else begin
          so_q <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // ****************************************************************
  // Write byte FIFO between the shifter and the packet buffer.
  // ****************************************************************

  // A push that meets a full FIFO is lost; the full flag warns the host.
  spcm_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (push_q),
    .in_ready  (push_ready),
    .in_data   (push_data_q),
    .out_valid (fifo_valid),
    .out_ready (drain),
    .out_data  (fifo_data)
  );

  // The buffer takes a byte each cycle unless another user holds it.
  assign drain = fifo_valid & ~mem_hold;

  // ****************************************************************
  // Packet buffer and its pointers.
  // ****************************************************************

  assign mem_rdata = buf_mem_q[buf_read_ptr_q];

  // Buffer storage carries no reset.
  always @(posedge clk) begin
    if (drain) begin
      buf_mem_q[buf_write_ptr_q] <= fifo_data;
    end
  end

  // Loads from the register file win over advances in the same cycle.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_read_ptr_q  <= `SPCM_PTR_RESET;
      buf_write_ptr_q <= `SPCM_PTR_RESET;
      wbuf_full_q     <= 1'b0;
    end else begin
      wbuf_full_q <= ~push_ready;
      if (rd_ptr_load) begin
        buf_read_ptr_q <= ptr_load_value;
      end else if (byte_done && state_q == ST_RBUF && auto_increment_en) begin
        buf_read_ptr_q <= rd_next;
      end
      if (wr_ptr_load) begin
        buf_write_ptr_q <= ptr_load_value;
      end else if (drain && auto_increment_en) begin
        buf_write_ptr_q <= wr_next;
      end
    end
  end

endmodule // spcm_spi_cmd

`default_nettype wire

// file: testbench/spcm_spi_cmd_sva.sv
// Concurrent checks on the ports of the serial command front end.
`timescale 1ns/1ns
`default_nettype none
module spcm_spi_cmd_sva #(
  parameter ADDR_W = 13
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              cs_n_pin,
  input wire logic              sck_pin,
  input wire logic              so_q,
  input wire logic              so_oe_q,
  input wire logic [ADDR_W-1:0] rx_region_start,
  input wire logic [ADDR_W-1:0] rx_region_end,
  input wire logic              rd_ptr_load,
  input wire logic              wr_ptr_load,
  input wire logic              reg_wr_q,
  input wire logic              soft_reset_q,
  input wire logic [ADDR_W-1:0] buf_read_ptr_q,
  input wire logic [ADDR_W-1:0] buf_write_ptr_q
);
  // One clock domain, so one clocking and one disable for all checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  oe_idle_a: assert property (cs_n_pin [*5] |-> !so_oe_q)
    else $error("serial output enabled while deselected");
  so_zero_a: assert property (!so_oe_q |-> !so_q)
    else $error("serial output not low while released");
  so_hold_a: assert property (sck_pin [*5] |-> $stable(so_q))
    else $error("serial output moved while clock high");
  wr_pulse_a: assert property (
    reg_wr_q |-> $past(sck_pin, 2) && $past(sck_pin, 3) ##1 !reg_wr_q)
    else $error("register write not a pulse after a rise");
  srst_pulse_a: assert property ($rose(soft_reset_q) |=> !soft_reset_q)
    else $error("soft reset pulse too long");
  wptr_step_a: assert property (
    $changed(buf_write_ptr_q) && !$past(wr_ptr_load) && !$past(wr_ptr_load, 2)
    |-> buf_write_ptr_q == $past(buf_write_ptr_q) + 1'b1)
    else $error("write pointer moved by other than one");
  rptr_wrap_a: assert property (
    $changed(buf_read_ptr_q) && !$past(rd_ptr_load) && !$past(rd_ptr_load, 2)
    && $past(buf_read_ptr_q) == $past(rx_region_end)
    |-> buf_read_ptr_q == $past(rx_region_start))
    else $error("read pointer missed receive wrap");
  rptr_step_a: assert property (
    $changed(buf_read_ptr_q) && !$past(rd_ptr_load) && !$past(rd_ptr_load, 2)
    && $past(buf_read_ptr_q) != $past(rx_region_end)
    |-> buf_read_ptr_q == $past(buf_read_ptr_q) + 1'b1)
    else $error("read pointer moved by other than one");
endmodule // spcm_spi_cmd_sva
`default_nettype wire

// file: testbench/spcm_host.sv
// Host side model: drives select, serial clock and data in clock mode zero.
`timescale 1ns/1ns
`default_nettype none
module spcm_host (
  input  wire logic clk,
  input  wire logic so,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  task automatic open_frame();
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic xbits(input logic [7:0] d, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      si = d[7-i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      r = {r[6:0], so};
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
  endtask
  // release select and invert the data line
  task automatic close_frame();
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    si   = ~si;
    repeat (4) @(negedge clk);
  endtask
endmodule // spcm_host
`default_nettype wire

// file: testbench/spcm_spi_cmd_test.sv
// Self-checking bench of the serial command front end.
`timescale 1ns/1ns
`default_nettype none
module spcm_spi_cmd_test;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cs_n, sck, si, so_q, so_oe_q, reg_wr_q, soft_reset_q, wbuf_full_q;
  logic        rd_ld = 1'b0;
  logic        wr_ld = 1'b0;
  logic        mem_hold = 1'b0;
  logic        auto_inc = 1'b1;
  logic [12:0] rx_start = 13'h0000;
  logic [12:0] rx_end = 13'h1000;
  logic [12:0] load_val = 13'h0000;
  logic [12:0] rd_ptr, wr_ptr;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  regs [32];
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_srst = 0;

  always #50 clk = ~clk;

  // Register file beside the block; low half of the bank is the plain class.
  always @(posedge clk) begin
    if (reg_wr_q === 1'b1) regs[reg_addr] <= reg_wdata;
    if (soft_reset_q === 1'b1) n_srst <= n_srst + 1;
  end

  spcm_host host (.clk(clk), .so(so_oe_q ? so_q : ~so_q), .cs_n(cs_n), .sck(sck), .si(si));

  spcm_spi_cmd dut (
    .clk(clk), .reset(reset), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
    .so_q(so_q), .so_oe_q(so_oe_q), .auto_increment_en(auto_inc),
    .rx_region_start(rx_start), .rx_region_end(rx_end), .rd_ptr_load(rd_ld),
    .wr_ptr_load(wr_ld), .ptr_load_value(load_val), .mem_hold(mem_hold),
    .reg_is_eth(reg_addr < 5'h10), .reg_rdata(regs[reg_addr]), .reg_addr_q(reg_addr),
    .reg_wdata_q(reg_wdata), .reg_wr_q(reg_wr_q), .soft_reset_q(soft_reset_q),
    .buf_read_ptr_q(rd_ptr), .buf_write_ptr_q(wr_ptr), .wbuf_full_q(wbuf_full_q));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One frame of an opcode and one data byte of n bits.
  task automatic wr1(input logic [7:0] op, input logic [7:0] d, input int n);
    logic [7:0] r;
    host.open_frame();
    host.xbits(op, 8, r);
    host.xbits(d, n, r);
    host.close_frame();
  endtask

  task automatic load_ptr(input logic rd, input logic [12:0] v);
    @(negedge clk);
    load_val = v;
    rd_ld = rd;
    wr_ld = !rd;
    @(negedge clk);
    rd_ld = 1'b0;
    wr_ld = 1'b0;
  endtask

  // Opens a buffer read at pointer p and compares n bytes with the table.
  task automatic buf_read(input logic [12:0] p, input logic [7:0] e [16], input int n);
    logic [7:0] r;
    load_ptr(1'b1, p);
    host.open_frame();
    host.xbits(8'h3A, 8, r);
    for (int i = 0; i < n; i++) begin
      host.xbits(8'h00, 8, r);
      chk(r, e[i]);
    end
    host.close_frame();
  endtask

  task automatic t_reg();
    logic [7:0] r;
    host.open_frame();
    host.xbits(8'h43, 8, r);
    host.xbits(8'h5A, 8, r);
    host.xbits(8'hA5, 8, r);
    host.close_frame();
    chk(regs[3], 8'hA5);
    wr1(8'h43, 8'hFF, 4);
    chk(regs[3], 8'hA5);
    host.open_frame();
    host.xbits(8'h03, 8, r);
    host.xbits(8'h00, 8, r);
    chk(r, 8'hA5);
    host.xbits(8'h00, 8, r);
    chk(r, 8'hA5);
    host.close_frame();
    chk(so_oe_q, 1'b0);
    host.open_frame();
    host.xbits(8'h14, 8, r);
    host.xbits(8'h00, 8, r);
    chk(r, 8'h00);
    host.xbits(8'h00, 8, r);
    chk(r, 8'h3C);
    host.close_frame();
  endtask

  task automatic t_bits();
    wr1(8'hA5, 8'h17, 8);
    chk(regs[5], 8'hE0);
    wr1(8'h85, 8'h0A, 8);
    chk(regs[5], 8'hEA);
    wr1(8'h85, 8'hFF, 4);
    chk(regs[5], 8'hEA);
    wr1(8'h94, 8'hFF, 8);
    chk(regs[20], 8'h3C);
  endtask

  task automatic t_buf();
    logic [7:0] r;
    logic [7:0] e [16];
    load_ptr(1'b0, 13'h1FFE);
    host.open_frame();
    host.xbits(8'h7A, 8, r);
    host.xbits(8'h11, 8, r);
    host.xbits(8'h22, 8, r);
    host.xbits(8'h33, 8, r);
    host.close_frame();
    chk(wr_ptr, 13'h0001);
    e[0] = 8'h11;
    e[1] = 8'h22;
    e[2] = 8'h33;
    buf_read(13'h1FFE, e, 3);
    chk(rd_ptr, 13'h0001);
    rx_end = 13'h1FFE;
    e[1] = 8'h33;
    buf_read(13'h1FFE, e, 2);
    chk(rd_ptr, 13'h0001);
  endtask

  task automatic t_fifo();
    logic [7:0] r;
    logic [7:0] e [16];
    int k;
    mem_hold = 1'b1;
    load_ptr(1'b0, 13'h0000);
    host.open_frame();
    host.xbits(8'h7A, 8, r);
    for (int i = 0; i < 17; i++) host.xbits(8'(i), 8, r);
    chk(wbuf_full_q, 1'b1);
    host.close_frame();
    mem_hold = 1'b0;
    for (k = 0; k < 100 && wr_ptr !== 13'h0010; k++) @(negedge clk);
    chk(wr_ptr, 13'h0010);
    for (int i = 0; i < 16; i++) e[i] = 8'(i);
    if (k < 100) buf_read(13'h0000, e, 16);
  endtask

  // Pointers hold without auto increment; refused commands change nothing.
  task automatic t_noinc();
    logic [7:0] r;
    logic [7:0] e [16];
    auto_inc = 1'b0;
    load_ptr(1'b0, 13'h0100);
    host.open_frame();
    host.xbits(8'h7A, 8, r);
    host.xbits(8'h44, 8, r);
    host.xbits(8'h55, 8, r);
    host.close_frame();
    chk(wr_ptr, 13'h0100);
    e[0] = 8'h55;
    e[1] = 8'h55;
    buf_read(13'h0100, e, 2);
    chk(rd_ptr, 13'h0100);
    auto_inc = 1'b1;
    wr1(8'h7B, 8'h66, 8);
    chk(wr_ptr, 13'h0100);
    wr1(8'hC3, 8'h66, 8);
    chk(regs[3], 8'hA5);
  endtask

  task automatic t_srst();
    logic [7:0] r;
    host.open_frame();
    host.xbits(8'hFF, 8, r);
    host.close_frame();
    chk(n_srst, 1);
    host.open_frame();
    host.xbits(8'hE0, 8, r);
    host.close_frame();
    chk(n_srst, 1);
  endtask

  initial begin
    for (int i = 0; i < 32; i++) regs[i] = 8'h00;
    regs[5] = 8'hF1;
    regs[20] = 8'h3C;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_reg();
    t_bits();
    t_buf();
    t_fifo();
    t_noinc();
    t_srst();
    results();
  end
endmodule // spcm_spi_cmd_test

bind spcm_spi_cmd spcm_spi_cmd_sva #(.ADDR_W(ADDR_W)) u_sva (
  .clk(clk), .reset(reset), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .so_q(so_q),
  .so_oe_q(so_oe_q), .rx_region_start(rx_region_start), .rx_region_end(rx_region_end),
  .rd_ptr_load(rd_ptr_load), .wr_ptr_load(wr_ptr_load), .reg_wr_q(reg_wr_q),
  .soft_reset_q(soft_reset_q), .buf_read_ptr_q(buf_read_ptr_q),
  .buf_write_ptr_q(buf_write_ptr_q));
`default_nettype wire
